// ===== bench/adc_power_mode_sequencer_bench.sv
// bench joining host and device ends of the power-mode sequencer
`default_nettype none
`define APMS_CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module adc_power_mode_sequencer_bench import apms_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] c; int pre; apms_mode_e m; apms_pwr_e p; logic nr;} apms_row_s;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [15:0] conv = 16'h0000;
  logic busy, done, ref_on, smp, nrdy, xd, sclk_q;
  logic [15:0] rx;
  logic [7:0] ctrl;
  apms_mode_e mode;
  apms_pwr_e pwr;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int n_smp, n_xd, n_rise;
  // --------------------------------------------------------------
  // mode sequence: byte sent, idle wait, mode, state, early sample
  // --------------------------------------------------------------
  apms_row_s rows [10] = '{
    '{8'h00, 0, APMS_NORMAL, APMS_PWR_ON, 1'b0},
    '{8'h08, 0, APMS_AUTO_SHUT, APMS_PWR_OFF, 1'b0},
    '{8'h08, 0, APMS_AUTO_SHUT, APMS_PWR_OFF, 1'b1},
    '{8'h0c, 0, APMS_AUTO_STBY, APMS_PWR_STBY, 1'b1},
    '{8'h0c, 0, APMS_AUTO_STBY, APMS_PWR_STBY, 1'b0},
    '{8'h04, 0, APMS_FULL_OFF, APMS_PWR_OFF, 1'b0},
    '{8'h08, 0, APMS_AUTO_SHUT, APMS_PWR_OFF, 1'b1},
    '{8'h04, 0, APMS_FULL_OFF, APMS_PWR_OFF, 1'b1},
    '{8'h00, 0, APMS_NORMAL, APMS_PWR_WAKING, 1'b1},
    '{8'h00, 250, APMS_NORMAL, APMS_PWR_ON, 1'b0}};
  apms_link_if link();
  apms_host u_apms_host (.core_clk(core_clk), .rst(rst), .ce(ce), .link(link), .start(start),
    .ctrl_word(tx), .busy(busy), .done(done), .rx_word(rx));
  // short standby wake so a wake fits before the sampling edge
  apms_dev #(.WAKE_STBY_CYC(2), .WAKE_SHUT_CYC(200)) u_apms_dev (.core_clk(core_clk), .rst(rst), .ce(ce),
    .link(link), .conv_result(conv), .ctrl_word(ctrl), .power_mode(mode), .power_state(pwr),
    .ref_on(ref_on), .sample_pulse(smp), .not_ready(nrdy), .xfer_done(xd));
  apms_link_asserts u_apms_link_asserts (.core_clk(core_clk), .rst(rst), .cs_n(link.cs_n),
    .sclk(link.sclk), .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe));
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    if (smp === 1'b1) n_smp++;
    if (xd === 1'b1) n_xd++;
    if (link.cs_n === 1'b0 && link.sclk === 1'b1 && sclk_q === 1'b0) n_rise++;
    sclk_q <= link.sclk;
    cyc++;
    if (cyc == 8000)
    begin
      error_cnt++;
      conclude();
    end
  end
  task conclude;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_done;
    int k;
    for (k = 0; k < 500 && done !== 1'b1; k++) @(negedge core_clk);
    if (done !== 1'b1) error_cnt++;
  endtask
  task automatic xfer(input logic [7:0] c, input int pre);
    repeat (pre) @(posedge core_clk);
    @(negedge core_clk);
    n_smp = 0;
    n_xd = 0;
    n_rise = 0;
    @(posedge core_clk);
    tx <= c;
    conv <= {8'h5a, c};
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    wait_done();
    repeat (6) @(negedge core_clk);
  endtask
  task chk_idle;
    @(negedge core_clk);
    `APMS_CHK("mode", APMS_NORMAL, mode)
    `APMS_CHK("state", APMS_PWR_ON, pwr)
    `APMS_CHK("ctrl", 8'h00, ctrl)
    `APMS_CHK("ref_on", 1'b1, ref_on)
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    chk_idle();
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 10; i++)
    begin
      xfer(rows[i].c, rows[i].pre);
      `APMS_CHK("mode", rows[i].m, mode)
      `APMS_CHK("state", rows[i].p, pwr)
      `APMS_CHK("not_ready", rows[i].nr, nrdy)
      `APMS_CHK("ctrl", rows[i].c, ctrl)
      `APMS_CHK("rx", {8'h5a, rows[i].c}, rx)
      `APMS_CHK("samples", 1, n_smp)
      `APMS_CHK("ends", 1, n_xd)
      `APMS_CHK("rises", 16, n_rise)
      if (rows[i].p != APMS_PWR_WAKING) `APMS_CHK("ref_on", rows[i].p != APMS_PWR_OFF, ref_on)
    end
    // back-to-back frames: start held across the first done
    @(negedge core_clk);
    n_smp = 0;
    n_rise = 0;
    @(posedge core_clk);
    start <= 1'b1;
    wait_done();
    @(posedge core_clk);
    start <= 1'b0;
    @(negedge core_clk);
    wait_done();
    repeat (6) @(negedge core_clk);
    `APMS_CHK("samples", 2, n_smp)
    `APMS_CHK("not_ready", 1'b0, nrdy)
    `APMS_CHK("rises", 32, n_rise)
    // enable low: a start pulse is ignored and nothing moves
    @(posedge core_clk);
    ce <= 1'b0;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (20) @(negedge core_clk);
    `APMS_CHK("frozen cs_n", 1'b1, link.cs_n)
    `APMS_CHK("frozen busy", 1'b0, busy)
    @(posedge core_clk);
    ce <= 1'b1;
    // reset out of full shutdown returns to powered normal mode
    xfer(8'h04, 0);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk_idle();
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    xfer(8'h00, 0);
    `APMS_CHK("not_ready", 1'b0, nrdy)
    conclude();
  end
endmodule
`default_nettype wire

// ===== bench/apms_link_asserts.sv
// link checks between the host end and the device end
`default_nettype none
module apms_link_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclk_q_ff;
  logic nxt_sclk_q;
  logic [4:0] rise_cnt_ff;
  logic [4:0] nxt_rise_cnt;
  // counts one cycle late, still settled long before select rises
  always_comb
  begin
    nxt_sclk_q = sclk;
    nxt_rise_cnt = cs_n ? 5'h00 : rise_cnt_ff + {4'h0, sclk & ~sclk_q_ff};
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_q_ff <= 1'b1;
      rise_cnt_ff <= 5'h00;
    end
    else
    begin
      sclk_q_ff <= nxt_sclk_q;
      rise_cnt_ff <= nxt_rise_cnt;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_release_deselect: assert property (cs_n [*8] |-> !dout_oe)
    else $error("dout driven while deselected");
  a_sclk_idle_high: assert property (cs_n |-> sclk)
    else $error("sclk low outside a frame");
  a_first_edge_fall: assert property ($fell(cs_n) |-> ##[1:11] $fell(sclk))
    else $error("first sclk edge not falling");
  a_half_period: assert property ($changed(sclk) |=> $stable(sclk) [*8])
    else $error("sclk half period too short");
  a_din_after_rise: assert property (!cs_n && $changed(din) |-> $fell(sclk) || $fell(cs_n))
    else $error("din moved away from a falling sclk edge");
  a_sixteen_rises: assert property ($rose(cs_n) |-> rise_cnt_ff == 5'h10)
    else $error("frame without sixteen rises");
  a_drive_in_frame: assert property (!cs_n && $rose(sclk) && rise_cnt_ff != 5'h00 |-> dout_oe)
    else $error("dout not driven in frame");
  a_frame_length: assert property ($fell(cs_n) |-> ##[329:333] $rose(cs_n))
    else $error("frame length wrong");
  c_frame: cover property ($rose(cs_n) && rise_cnt_ff == 5'h10);
  c_select: cover property ($fell(cs_n));
  c_drive: cover property ($rose(dout_oe));
endmodule
`default_nettype wire

// ===== hdl/apms_dev.sv
// device end: power-mode sequencer driven by select and serial clock
`default_nettype none
module apms_dev
  import apms_pkg::*;
#(
  parameter int WAKE_STBY_CYC = APMS_WAKE_STBY_CYC,
  parameter int WAKE_SHUT_CYC = APMS_WAKE_SHUT_CYC
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  apms_link_if.dev link,
  input wire logic [15:0] conv_result,
  output logic [7:0] ctrl_word,
  output apms_mode_e power_mode,
  output apms_pwr_e power_state,
  output logic ref_on,
  output logic sample_pulse,
  output logic not_ready,
  output logic xfer_done
);
  initial
  begin
    if (WAKE_STBY_CYC < 1 || WAKE_SHUT_CYC < 1 || WAKE_SHUT_CYC > 65535 || WAKE_STBY_CYC > 65535)
      $error("wake counts out of range");
  end
  // --------------------------------------------------------------------------
  // pin sampling
  // --------------------------------------------------------------------------
  logic cs_s, sclk_s, din_s;
  apms_sync3 u_cs (.core_clk(core_clk), .rst(rst), .ce(ce), .async_in(link.cs_n), .level(cs_s));
  apms_sync3 u_ck (.core_clk(core_clk), .rst(rst), .ce(ce), .async_in(link.sclk), .level(sclk_s));
  apms_sync3 u_di (.core_clk(core_clk), .rst(rst), .ce(ce), .async_in(link.din), .level(din_s));
  logic cs_d_ff, sclk_d_ff;
  logic cs_fall, cs_rise, ck_rise, ck_fall;
  assign cs_fall = cs_d_ff & ~cs_s;
  assign cs_rise = ~cs_d_ff & cs_s;
  assign ck_rise = ~cs_s & ~sclk_d_ff & sclk_s;
  assign ck_fall = ~cs_s & sclk_d_ff & ~sclk_s;
  // --------------------------------------------------------------------------
  // transfer and power state
  // --------------------------------------------------------------------------
  logic [4:0] rise_ff, nxt_rise;
  logic first_fall_ff, nxt_first_fall;
  logic [7:0] shreg_ff, nxt_shreg;
  logic [7:0] ctrl_ff, nxt_ctrl;
  apms_mode_e mode_ff, nxt_mode;
  apms_pwr_e pwr_ff, nxt_pwr;
  logic [15:0] wake_ff, nxt_wake;
  logic [15:0] tx_ff, nxt_tx;
  logic dout_ff, nxt_dout, oe_ff, nxt_oe;
  logic ref_ff, nxt_ref, samp_ff, nxt_samp, nrdy_ff, nxt_nrdy, done_ff, nxt_done;
  logic [7:0] word_in;
  apms_mode_e new_mode;
  always_comb
  begin
    nxt_rise = rise_ff;
    nxt_first_fall = first_fall_ff;
    nxt_shreg = shreg_ff;
    nxt_ctrl = ctrl_ff;
    nxt_mode = mode_ff;
    nxt_pwr = pwr_ff;
    nxt_wake = wake_ff;
    nxt_tx = tx_ff;
    nxt_dout = dout_ff;
    nxt_oe = ~cs_s;
    nxt_samp = 1'b0;
    nxt_nrdy = nrdy_ff;
    nxt_done = 1'b0;
    word_in = {shreg_ff[6:0], din_s};
    new_mode = apms_mode_e'({word_in[APMS_PM_HI_POS], word_in[APMS_PM_LO_POS]});
    // wake timer runs on core clock, so it needs no further link edges
    if (pwr_ff == APMS_PWR_WAKING)
    begin
      if (wake_ff == 16'h0001)
        nxt_pwr = APMS_PWR_ON;
      nxt_wake = wake_ff - 16'h0001;
    end
    if (cs_fall)
    begin
      nxt_rise = '0;
      nxt_first_fall = 1'b1;
      nxt_tx = conv_result;
      nxt_dout = 1'b0;
      nxt_nrdy = 1'b0;
    end
    if (ck_fall)
    begin
      nxt_dout = tx_ff[15];
      nxt_tx = {tx_ff[14:0], 1'b0};
      nxt_first_fall = 1'b0;
      // full shutdown does not wake on link edges; auto modes wake here
      if (first_fall_ff && (mode_ff == APMS_AUTO_SHUT || mode_ff == APMS_AUTO_STBY)
          && (pwr_ff == APMS_PWR_OFF || pwr_ff == APMS_PWR_STBY))
      begin
        nxt_pwr = APMS_PWR_WAKING;
        nxt_wake = (pwr_ff == APMS_PWR_STBY) ? 16'(WAKE_STBY_CYC) : 16'(WAKE_SHUT_CYC);
      end
    end
    if (ck_rise && rise_ff < 5'(APMS_XFER_BITS))
    begin
      nxt_rise = rise_ff + 5'h01;
      if (rise_ff < 5'(APMS_CTRL_BITS))
        nxt_shreg = word_in;
      if (rise_ff == 5'(APMS_CTRL_BITS - 1))
        nxt_ctrl = word_in;
      if (rise_ff == 5'(APMS_SAMPLE_EDGE - 1))
      begin
        nxt_samp = 1'b1;
        nxt_nrdy = (pwr_ff != APMS_PWR_ON);
      end
      if (rise_ff == 5'(APMS_XFER_BITS - 1))
      begin
        // mode bits take effect here, at the end of the conversion
        nxt_mode = apms_mode_e'({ctrl_ff[APMS_PM_HI_POS], ctrl_ff[APMS_PM_LO_POS]});
        nxt_done = 1'b1;
        case (nxt_mode)
          APMS_NORMAL:
            if (pwr_ff != APMS_PWR_ON && pwr_ff != APMS_PWR_WAKING)
            begin
              nxt_pwr = APMS_PWR_WAKING;
              nxt_wake = (pwr_ff == APMS_PWR_STBY) ? 16'(WAKE_STBY_CYC) : 16'(WAKE_SHUT_CYC);
            end
          APMS_FULL_OFF: nxt_pwr = APMS_PWR_OFF;
          APMS_AUTO_SHUT: nxt_pwr = APMS_PWR_OFF;
          APMS_AUTO_STBY: nxt_pwr = APMS_PWR_STBY;
          default: nxt_pwr = pwr_ff;
        endcase
      end
    end
    if (cs_rise)
      nxt_first_fall = 1'b0;
    nxt_ref = (nxt_pwr != APMS_PWR_OFF) && !(nxt_ctrl[APMS_REF_OFF_POS]);
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_d_ff <= 1'b1;
      sclk_d_ff <= 1'b1;
      rise_ff <= '0;
      first_fall_ff <= 1'b0;
      shreg_ff <= '0;
      ctrl_ff <= APMS_CTRL_RST;
      mode_ff <= APMS_NORMAL;
      pwr_ff <= APMS_PWR_ON;
      wake_ff <= '0;
      tx_ff <= '0;
      dout_ff <= 1'b0;
      oe_ff <= 1'b0;
      ref_ff <= 1'b1;
      samp_ff <= 1'b0;
      nrdy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (ce)
    begin
      cs_d_ff <= cs_s;
      sclk_d_ff <= sclk_s;
      rise_ff <= nxt_rise;
      first_fall_ff <= nxt_first_fall;
      shreg_ff <= nxt_shreg;
      ctrl_ff <= nxt_ctrl;
      mode_ff <= nxt_mode;
      pwr_ff <= nxt_pwr;
      wake_ff <= nxt_wake;
      tx_ff <= nxt_tx;
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
      ref_ff <= nxt_ref;
      samp_ff <= nxt_samp;
      nrdy_ff <= nxt_nrdy;
      done_ff <= nxt_done;
    end
  end
  assign link.dout = dout_ff;
  assign link.dout_oe = oe_ff;
  assign ctrl_word = ctrl_ff;
  assign power_mode = mode_ff;
  assign power_state = pwr_ff;
  assign ref_on = ref_ff;
  assign sample_pulse = samp_ff;
  assign not_ready = nrdy_ff;
  assign xfer_done = done_ff;
endmodule
`default_nettype wire

// ===== hdl/apms_host.sv
// host end: runs sixteen-clock transfers carrying a control byte
`default_nettype none
module apms_host
  import apms_pkg::*;
#(
  parameter int HALF_CYC = APMS_SCLK_HALF_CYC,
  parameter int GAP_HALVES = 0
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  apms_link_if.host link,
  input wire logic start,
  input wire logic [7:0] ctrl_word,
  output logic busy,
  output logic done,
  output logic [15:0] rx_word
);
  initial
  begin
    if (HALF_CYC <= APMS_ROUND_TRIP_CYC || GAP_HALVES < 0)
      $error("bad host timing parameters");
  end
  typedef enum logic [1:0] {H_IDLE, H_LEAD, H_RUN, H_END} apms_hst_e;
  apms_hst_e st_ff, nxt_st;
  logic [15:0] div_ff, nxt_div;
  logic [5:0] half_ff, nxt_half;
  logic [7:0] tx_ff, nxt_tx;
  logic [15:0] rx_ff, nxt_rx;
  logic cs_ff, nxt_cs, sclk_ff, nxt_sclk, din_ff, nxt_din, done_ff, nxt_done, busy_ff, nxt_busy;
  logic dout_s;
  apms_sync3 u_dsync (.core_clk(core_clk), .rst(rst), .ce(ce), .async_in(link.dout), .level(dout_s));
  always_comb
  begin
    nxt_st = st_ff;
    nxt_div = div_ff;
    nxt_half = half_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_cs = cs_ff;
    nxt_sclk = sclk_ff;
    nxt_din = din_ff;
    nxt_done = 1'b0;
    nxt_busy = busy_ff;
    case (st_ff)
      H_IDLE:
        if (start)
        begin
          nxt_cs = 1'b0;
          nxt_busy = 1'b1;
          // first falling edge re-presents the msb, so rise 1 still sees it
          nxt_tx = ctrl_word;
          nxt_din = ctrl_word[7];
          nxt_div = '0;
          nxt_half = '0;
          nxt_st = H_LEAD;
        end
      H_LEAD, H_RUN:
        if (div_ff == 16'(HALF_CYC - 1))
        begin
          nxt_div = '0;
          nxt_sclk = ~sclk_ff;
          nxt_st = H_RUN;
          if (sclk_ff)
          begin
            nxt_din = tx_ff[7];
            nxt_tx = tx_ff << 1;
          end
          else
            nxt_rx = {rx_ff[14:0], dout_s};
          nxt_half = half_ff + 6'h01;
          if (half_ff == 6'(2 * APMS_XFER_BITS - 1))
            nxt_st = H_END;
        end
        else
          nxt_div = div_ff + 16'h0001;
      H_END:
      begin
        nxt_div = div_ff + 16'h0001;
        if (div_ff == 16'(HALF_CYC * (1 + GAP_HALVES)))
          nxt_cs = 1'b1;
        // select stands high two edges; a one-cycle high is lost in the far filter
        if (cs_ff)
        begin
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
          nxt_st = H_IDLE;
        end
      end
      default:
        nxt_st = H_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= H_IDLE;
      div_ff <= '0;
      half_ff <= '0;
      tx_ff <= '0;
      rx_ff <= '0;
      cs_ff <= 1'b1;
      sclk_ff <= 1'b1;
      din_ff <= 1'b0;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
      div_ff <= nxt_div;
      half_ff <= nxt_half;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      cs_ff <= nxt_cs;
      sclk_ff <= nxt_sclk;
      din_ff <= nxt_din;
      done_ff <= nxt_done;
      busy_ff <= nxt_busy;
    end
  end
  assign link.cs_n = cs_ff;
  assign link.sclk = sclk_ff;
  assign link.din = din_ff;
  assign busy = busy_ff;
  assign done = done_ff;
  assign rx_word = rx_ff;
endmodule
`default_nettype wire

// ===== hdl/apms_sync3.sv
// three-stage synchroniser with agreement filter
`default_nettype none
module apms_sync3 (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic async_in,
  output logic level
);
  logic [2:0] sh_ff;
  logic [2:0] nxt_sh;
  logic lvl_ff;
  logic nxt_lvl;
  always_comb
  begin
    nxt_sh = {sh_ff[1:0], async_in};
    nxt_lvl = lvl_ff;
    // stage 0 is read only by stage 1; stages 1 and 2 must agree
    if (sh_ff[1] == sh_ff[2])
      nxt_lvl = sh_ff[2];
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sh_ff <= 3'h7;
      lvl_ff <= 1'b1;
    end
    else if (ce)
    begin
      sh_ff <= nxt_sh;
      lvl_ff <= nxt_lvl;
    end
  end
  assign level = lvl_ff;
endmodule
`default_nettype wire

// ===== inc/apms_link_if.sv
// serial link between host and converter
`default_nettype none
interface apms_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  modport host (output cs_n, output sclk, output din, input dout, input dout_oe);
  modport dev (input cs_n, input sclk, input din, output dout, output dout_oe);
endinterface
`default_nettype wire

// ===== inc/apms_pkg.sv
// package of constants and types for the converter power-mode sequencer
// --------------------------------------------------------------------------
// Contract
// - mode 00 normal, 01 off, 10 autoshut, 11 autostandby
// - auto modes power down on 16th rising edge
// - auto modes wake on first falling edge
// - full shutdown left only by writing normal; the code also leaves it on writing 10 or 11
// - new mode acts once control word updated
// - supply-up starts powered in normal mode
// - standby wake takes about 1 us
// - shutdown wake takes about 5 us
// - standby wake fits within one transfer
// - first eight data bits load control word
// - host writes zero mode to stay normal
// - sample on second rising edge after select
// - sixteen clocks per transfer, one select low
// - normal mode allows back-to-back transfers
// - full shutdown powers all, keeps control word
// - off to autoshut stays down until next conversion
// - host waits 5 us before sampling edge; apms_host reaches it four half periods after select falls
// - host escapes autoshut by writing normal
// - standby keeps reference, wakes on falling edge
// - standby entered on last rising edge
// - control word written every transfer, eight edges
// - host keeps reference-disable zero in standby
// --------------------------------------------------------------------------
`default_nettype none
package apms_pkg;
  typedef enum logic [1:0] {APMS_NORMAL, APMS_FULL_OFF, APMS_AUTO_SHUT, APMS_AUTO_STBY} apms_mode_e;
  typedef enum logic [1:0] {APMS_PWR_ON, APMS_PWR_WAKING, APMS_PWR_STBY, APMS_PWR_OFF} apms_pwr_e;
  localparam int APMS_CLK_MHZ = 40;
  localparam int APMS_WAKE_STBY_NS = 1000;
  localparam int APMS_WAKE_SHUT_NS = 5000;
  localparam int APMS_WAKE_STBY_CYC = (APMS_WAKE_STBY_NS * APMS_CLK_MHZ + 999) / 1000;
  localparam int APMS_WAKE_SHUT_CYC = (APMS_WAKE_SHUT_NS * APMS_CLK_MHZ + 999) / 1000;
  localparam int APMS_XFER_BITS = 16;
  localparam int APMS_CTRL_BITS = 8;
  localparam int APMS_SAMPLE_EDGE = 2;
  localparam int APMS_PM_HI_POS = 3;
  localparam int APMS_PM_LO_POS = 2;
  localparam int APMS_REF_OFF_POS = 1;
  localparam logic [7:0] APMS_CTRL_RST = 8'h00;
  // pin change to read data back at the host: two four-flop filters plus the device dout register
  localparam int APMS_ROUND_TRIP_CYC = 9;
  // a link half period must outlast the round trip, else read bits land one rise late
  localparam int APMS_SCLK_HALF_CYC = 10;
endpackage
`default_nettype wire
